// *** rtl/dhsc_counter.sv ***
// one statistics counter: hit qualification, prescaler, count update and event outputs
// assumes all inputs are on sys_clk; register values come from the register file in the top
`timescale 1ns/1ps
module dhsc_counter
   import dhsc_pkg::*;
#(
   parameter int DESC_W = DHSC_DESC_W
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // configuration
   input wire logic [63:0] hit_filter,
   input wire logic [DHSC_ACT_USED_W-1:0] action,
   input wire logic [31:0] reload_value,
   input wire logic load_cmd,
   // request decode
   input wire logic req_granted,
   input wire logic io_request_flag,
   input wire logic memory_request_flag,
   input wire logic [DESC_W-1:0] descriptor_match_vector,
   // status
   output logic [31:0] count,
   output logic async_error_out,
   output logic async_sysmgmt_out
);
   logic [DESC_W-1:0] io_descriptor_hit_mask;
   logic [DESC_W-1:0] memory_descriptor_hit_mask;
   logic [15:0] decrement_prescale;
   logic [15:0] prescale_reg;
   logic [31:0] count_reg;
   logic [31:0] count_next;
   logic hit;
   logic tick;
   logic is_zero;
   logic do_load;
   logic do_dec;
   logic wrap;

   assign io_descriptor_hit_mask = hit_filter[DHSC_IO_MASK_LSB +: DESC_W];
   assign memory_descriptor_hit_mask = hit_filter[DESC_W-1:0];
   assign decrement_prescale = action[DHSC_PRESCALE_LSB +: DHSC_PRESCALE_W];
   assign wrap = action[DHSC_BIT_WRAP];

   // hits taken only from granted requests
   assign hit = req_granted
      && ((|(io_descriptor_hit_mask & descriptor_match_vector) && io_request_flag)
      || (|(memory_descriptor_hit_mask & descriptor_match_vector) && memory_request_flag));

   // free-running prescaler, one tick per prescale+1 cycles
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         prescale_reg <= DHSC_PRESCALE_RESET;
      end else if (prescale_reg >= decrement_prescale) begin
         prescale_reg <= DHSC_PRESCALE_RESET;
      end else begin
         prescale_reg <= prescale_reg + 16'h0001;
      end
   end
   assign tick = (prescale_reg >= decrement_prescale);

   assign is_zero = (count_reg == 32'h00000000);
   assign do_load = load_cmd || (hit && action[DHSC_BIT_HIT_LOAD]);
   assign do_dec = (hit && action[DHSC_BIT_DECREMENT_ON_MATCH])
      || (tick && action[DHSC_BIT_FREE_DEC]);

   always_comb begin
      count_next = count_reg;
      if (do_load) begin
         count_next = reload_value;
      end else if (do_dec && (!is_zero || wrap)) begin
         count_next = count_reg - 32'h00000001;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_reg <= DHSC_COUNT_RESET;
      end else begin
         count_reg <= count_next;
      end
   end

   assign count = count_reg;
   assign async_error_out = (action[DHSC_BIT_ZERO_ERR] && is_zero)
      || (action[DHSC_BIT_HIT_ERR] && hit);
   assign async_sysmgmt_out = (action[DHSC_BIT_SYSMGMT_ON_EMPTY] && is_zero)
      || (action[DHSC_BIT_SYSMGMT_ON_MATCH] && hit);

   chk_zero_stops: assert property (@(posedge sys_clk) disable iff (!rst_n)
      is_zero && !wrap && !do_load |=> is_zero)
      else $error("count left zero without wrap or load");
   chk_wrap_rolls: assert property (@(posedge sys_clk) disable iff (!rst_n)
      is_zero && wrap && do_dec && !do_load |=> count_reg == 32'hffffffff)
      else $error("count did not roll to all ones");
   chk_load_value: assert property (@(posedge sys_clk) disable iff (!rst_n)
      do_load |=> count_reg == $past(reload_value))
      else $error("load did not copy reload value");
   chk_decrement_on_match: assert property (@(posedge sys_clk) disable iff (!rst_n)
      hit && action[DHSC_BIT_DECREMENT_ON_MATCH] && !do_load && !is_zero
      |=> count_reg == $past(count_reg) - 32'h00000001)
      else $error("hit did not decrement count");
   chk_no_grant: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !req_granted && !load_cmd && !(tick && action[DHSC_BIT_FREE_DEC])
      |=> count_reg == $past(count_reg))
      else $error("count moved without a granted request");
   chk_zero_err: assert property (@(posedge sys_clk) disable iff (!rst_n)
      action[DHSC_BIT_ZERO_ERR] && is_zero |-> async_error_out)
      else $error("no error at zero");
   chk_sysmgmt_on_empty: assert property (@(posedge sys_clk) disable iff (!rst_n)
      action[DHSC_BIT_SYSMGMT_ON_EMPTY] && is_zero |-> async_sysmgmt_out)
      else $error("no management event at zero");
   chk_hit_err: assert property (@(posedge sys_clk) disable iff (!rst_n)
      hit && action[DHSC_BIT_HIT_ERR] |-> async_error_out)
      else $error("no error on hit");
   chk_sysmgmt_on_match: assert property (@(posedge sys_clk) disable iff (!rst_n)
      hit && action[DHSC_BIT_SYSMGMT_ON_MATCH] |-> async_sysmgmt_out)
      else $error("no management event on hit");
   chk_free_pace: assert property (@(posedge sys_clk) disable iff (!rst_n)
      action[DHSC_BIT_FREE_DEC] && !action[DHSC_BIT_DECREMENT_ON_MATCH] && !do_load && !tick
      |=> count_reg == $past(count_reg))
      else $error("free decrement off a prescale tick");
endmodule // dhsc_counter

// *** rtl/dhsc_pkg.sv ***
// package for the descriptor hit statistics counters: register addresses, field positions, reset values
// assumes a 32-bit model-specific register address and 64-bit register data
// Overview of operation
// - upper half of counter register is reload value, copied to count on load.
// - reading counter register low half returns the present count.
// - hit is OR of masked match vector for io requests or memory requests.
// - mask low half enables memory descriptor match bits one by one.
// - hits count only for requests that have won arbitration.
// - 16-bit prescale field paces free-running automatic decrements.
// - wrap clear: count stops at zero.
// - wrap set: decrement from zero rolls to all ones.
// - error-on-empty asserts async error while count is zero.
// - management-on-empty asserts async management event while count is zero.
// - free-decrement decrements on prescaled clock ticks, not hits.
// - free decrement pauses on a load cycle and at zero without wrap.
// - error-on-match makes every qualified hit raise async error.
// - decrement-on-match decrements the counter by one per qualified hit.
// - reload-on-match reloads the counter from reload value per qualified hit.
// - management-on-match raises async management event per qualified hit.
package dhsc_pkg;
   localparam int DHSC_NUM_CNT = 3;
   localparam int DHSC_DESC_W = 32;
   localparam logic [31:0] DHSC_BASE_ADDR = 32'h510100a0;
   // per-counter stride and register positions within the group of four
   localparam logic [31:0] DHSC_STRIDE = 32'h00000004;
   localparam logic [1:0] DHSC_OFS_COUNT = 2'h0;
   localparam logic [1:0] DHSC_OFS_FILTER = 2'h1;
   localparam logic [1:0] DHSC_OFS_ACTION = 2'h2;
   localparam logic [31:0] DHSC_ADDR_FILTER_0 = 32'h510100a1;
   localparam logic [31:0] DHSC_ADDR_ACTION_0 = 32'h510100a2;
   localparam logic [31:0] DHSC_ADDR_FILTER_1 = 32'h510100a5;
   localparam logic [31:0] DHSC_ADDR_ACTION_1 = 32'h510100a6;
   localparam logic [31:0] DHSC_ADDR_FILTER_2 = 32'h510100a9;
   localparam logic [31:0] DHSC_ADDR_ACTION_2 = 32'h510100aa;
   localparam int DHSC_RELOAD_LSB = 32;
   localparam int DHSC_IO_MASK_LSB = 32;
   localparam int DHSC_PRESCALE_LSB = 8;
   localparam int DHSC_PRESCALE_W = 16;
   localparam int DHSC_ACT_USED_W = 24;
   localparam int DHSC_BIT_WRAP = 7;
   localparam int DHSC_BIT_ZERO_ERR = 6;
   localparam int DHSC_BIT_SYSMGMT_ON_EMPTY = 5;
   localparam int DHSC_BIT_FREE_DEC = 4;
   localparam int DHSC_BIT_HIT_ERR = 3;
   localparam int DHSC_BIT_SYSMGMT_ON_MATCH = 2;
   localparam int DHSC_BIT_DECREMENT_ON_MATCH = 1;
   localparam int DHSC_BIT_HIT_LOAD = 0;
   localparam logic [63:0] DHSC_RESET_VAL = 64'h0000000000000000;
   localparam logic [31:0] DHSC_COUNT_RESET = 32'h00000000;
   localparam logic [15:0] DHSC_PRESCALE_RESET = 16'h0000;
endpackage

// *** rtl/dhsc_top.sv ***
// three descriptor hit statistics counters behind the model-specific register port
// assumes register accesses and request decode come from logic on sys_clk; reads are combinational
`timescale 1ns/1ps
module dhsc_top
   import dhsc_pkg::*;
#(
   parameter int DESC_W = DHSC_DESC_W
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // model-specific register port
   input wire logic [31:0] msr_addr,
   input wire logic msr_wr,
   input wire logic [63:0] msr_wdata,
   output logic [63:0] msr_rdata,
   output logic msr_hit,
   // request decode
   input wire logic req_granted,
   input wire logic io_request_flag,
   input wire logic memory_request_flag,
   input wire logic [DESC_W-1:0] descriptor_match_vector,
   // events
   output logic async_error_out,
   output logic async_sysmgmt_out
);
   logic [63:0] filter_reg [DHSC_NUM_CNT];
   logic [63:0] action_reg [DHSC_NUM_CNT];
   logic [31:0] reload_reg [DHSC_NUM_CNT];
   logic [31:0] count_w [DHSC_NUM_CNT];
   logic [DHSC_NUM_CNT-1:0] err_w;
   logic [DHSC_NUM_CNT-1:0] smi_w;
   logic [DHSC_NUM_CNT-1:0] load_w;

   function automatic logic sel(input logic [31:0] addr, input int idx, input logic [1:0] ofs);
      sel = (addr == DHSC_BASE_ADDR + DHSC_STRIDE * 32'(idx) + {30'h0, ofs});
   endfunction

   genvar g;
   for (g = 0; g < DHSC_NUM_CNT; g++) begin : gen_cnt
      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            filter_reg[g] <= DHSC_RESET_VAL;
            action_reg[g] <= DHSC_RESET_VAL;
            reload_reg[g] <= DHSC_COUNT_RESET;
         end else begin
            if (msr_wr && sel(msr_addr, g, DHSC_OFS_FILTER)) begin
               filter_reg[g] <= msr_wdata;
            end
            // reserved action bits kept as written, software writes back as read
            if (msr_wr && sel(msr_addr, g, DHSC_OFS_ACTION)) begin
               action_reg[g] <= msr_wdata;
            end
            if (msr_wr && sel(msr_addr, g, DHSC_OFS_COUNT)) begin
               reload_reg[g] <= msr_wdata[DHSC_RELOAD_LSB +: 32];
            end
         end
      end
      // writing the counter register commands a load of the written reload value
      assign load_w[g] = msr_wr && sel(msr_addr, g, DHSC_OFS_COUNT);

      dhsc_counter #(.DESC_W(DESC_W)) u_cnt (
         .sys_clk(sys_clk),
         .rst_n(rst_n),
         .hit_filter(filter_reg[g]),
         .action(action_reg[g][DHSC_ACT_USED_W-1:0]),
         .reload_value(load_w[g] ? msr_wdata[DHSC_RELOAD_LSB +: 32] : reload_reg[g]),
         .load_cmd(load_w[g]),
         .req_granted(req_granted),
         .io_request_flag(io_request_flag),
         .memory_request_flag(memory_request_flag),
         .descriptor_match_vector(descriptor_match_vector),
         .count(count_w[g]),
         .async_error_out(err_w[g]),
         .async_sysmgmt_out(smi_w[g])
      );
   end

   always_comb begin
      msr_rdata = 64'h0000000000000000;
      msr_hit = 1'b0;
      for (int i = 0; i < DHSC_NUM_CNT; i++) begin
         if (sel(msr_addr, i, DHSC_OFS_COUNT)) begin
            msr_rdata = {reload_reg[i], count_w[i]};
            msr_hit = 1'b1;
         end
         if (sel(msr_addr, i, DHSC_OFS_FILTER)) begin
            msr_rdata = filter_reg[i];
            msr_hit = 1'b1;
         end
         if (sel(msr_addr, i, DHSC_OFS_ACTION)) begin
            msr_rdata = action_reg[i];
            msr_hit = 1'b1;
         end
      end
   end

   assign async_error_out = |err_w;
   assign async_sysmgmt_out = |smi_w;

   chk_read_count: assert property (@(posedge sys_clk) disable iff (!rst_n)
      sel(msr_addr, 0, DHSC_OFS_COUNT) |-> msr_rdata[31:0] == count_w[0])
      else $error("counter read does not show count");
endmodule // dhsc_top

// *** test/test_descriptor_hit_stat_counter.sv ***
// testbench for the three descriptor hit statistics counters
// assumes the register port and request decode are driven from the 250 MHz sys_clk
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin error_cnt++; \
   $display("[FAIL] %0t got %0h expected %0h", $time, (got), (exp)); end end
module test_descriptor_hit_stat_counter;
   import dhsc_pkg::*;
   localparam logic [31:0] A0 = DHSC_BASE_ADDR;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [31:0] msr_addr = 32'h0;
   logic msr_wr = 1'b0;
   logic [63:0] msr_wdata = 64'h0;
   logic [63:0] msr_rdata;
   logic msr_hit;
   logic req_granted = 1'b0;
   logic io_request_flag = 1'b0;
   logic memory_request_flag = 1'b0;
   logic [31:0] descriptor_match_vector = 32'h0;
   logic async_error_out;
   logic async_sysmgmt_out;
   logic [31:0] c1;
   int error_cnt = 0;
   int tests_run = 0;

   dhsc_top i_dhsc_top (.sys_clk(sys_clk), .rst_n(rst_n), .msr_addr(msr_addr), .msr_wr(msr_wr),
      .msr_wdata(msr_wdata), .msr_rdata(msr_rdata), .msr_hit(msr_hit), .req_granted(req_granted),
      .io_request_flag(io_request_flag), .memory_request_flag(memory_request_flag),
      .descriptor_match_vector(descriptor_match_vector), .async_error_out(async_error_out),
      .async_sysmgmt_out(async_sysmgmt_out));

   always #2 sys_clk = ~sys_clk;

   // reserved upper bits are written back as zero, as read after reset
   function automatic logic [63:0] act(input logic [15:0] pre, input logic [7:0] b);
      return {40'h0, pre, b};
   endfunction

   task automatic wr(input logic [31:0] a, input logic [63:0] d);
      @(posedge sys_clk);
      msr_addr <= a;
      msr_wdata <= d;
      msr_wr <= 1'b1;
      @(posedge sys_clk);
      msr_wr <= 1'b0;
   endtask

   task automatic rd(input logic [31:0] a, input logic [63:0] exp);
      @(posedge sys_clk);
      msr_addr <= a;
      #1;
      `CHK(msr_rdata, exp)
   endtask

   // one request cycle; event outputs are checked inside the cycle
   task automatic hit(input logic io, input logic mem, input logic [31:0] vec, input logic gr,
      input logic err, input logic smi);
      @(posedge sys_clk);
      req_granted <= gr;
      io_request_flag <= io;
      memory_request_flag <= mem;
      descriptor_match_vector <= vec;
      #1;
      `CHK(async_error_out, err)
      `CHK(async_sysmgmt_out, smi)
      @(posedge sys_clk);
      req_granted <= 1'b0;
   endtask

   task report_and_stop;
      $display("errors %0d comparisons %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (2000) @(posedge sys_clk);
      error_cnt++;
      report_and_stop();
   end

   initial begin
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         rd(A0 + 4 * i, 64'h0);
         rd(A0 + 4 * i + 1, 64'h0);
         rd(A0 + 4 * i + 2, 64'h0);
      end
      rd(A0 + 3, 64'h0);
      `CHK(msr_hit, 1'b0)
      wr(A0, {32'h5, 32'h0});
      rd(A0, {32'h5, 32'h5});
      `CHK(msr_hit, 1'b1)
      wr(A0 + 1, {32'h2, 32'h1});
      rd(A0 + 1, {32'h2, 32'h1});
      wr(A0 + 2, act(16'h0, 8'h02));
      rd(A0 + 2, act(16'h0, 8'h02));
      hit(1'b1, 1'b0, 32'h2, 1'b1, 1'b0, 1'b0);
      rd(A0, {32'h5, 32'h4});
      hit(1'b1, 1'b0, 32'h1, 1'b1, 1'b0, 1'b0);
      rd(A0, {32'h5, 32'h4});
      hit(1'b0, 1'b1, 32'h1, 1'b1, 1'b0, 1'b0);
      rd(A0, {32'h5, 32'h3});
      hit(1'b0, 1'b1, 32'h1, 1'b0, 1'b0, 1'b0);
      rd(A0, {32'h5, 32'h3});
      rd(A0 + 4, 64'h0);
      wr(A0 + 2, act(16'h0, 8'h0d));
      hit(1'b0, 1'b1, 32'h1, 1'b1, 1'b1, 1'b1);
      rd(A0, {32'h5, 32'h5});
      // count down to zero with both empty events enabled, no wrap
      wr(A0, {32'h1, 32'h0});
      wr(A0 + 2, act(16'h0, 8'h62));
      hit(1'b0, 1'b1, 32'h1, 1'b1, 1'b0, 1'b0);
      rd(A0, {32'h1, 32'h0});
      `CHK(async_error_out, 1'b1)
      `CHK(async_sysmgmt_out, 1'b1)
      hit(1'b0, 1'b1, 32'h1, 1'b1, 1'b1, 1'b1);
      rd(A0, {32'h1, 32'h0});
      wr(A0 + 2, act(16'h0, 8'h82));
      hit(1'b0, 1'b1, 32'h1, 1'b1, 1'b0, 1'b0);
      rd(A0, {32'h1, 32'hffffffff});
      // counter 1 on its own: empty error shows on the shared output, counter 0 untouched
      wr(A0 + 6, act(16'h0, 8'h40));
      #1;
      `CHK(async_error_out, 1'b1)
      `CHK(async_sysmgmt_out, 1'b0)
      wr(A0 + 4, {32'h7, 32'h0});
      rd(A0 + 4, {32'h7, 32'h7});
      `CHK(async_error_out, 1'b0)
      rd(A0, {32'h1, 32'hffffffff});
      // free decrement, one step every four cycles
      wr(A0, {32'h64, 32'h0});
      wr(A0 + 2, act(16'h3, 8'h10));
      rd(A0 + 2, act(16'h3, 8'h10));
      @(posedge sys_clk);
      msr_addr <= A0;
      #1;
      c1 = msr_rdata[31:0];
      repeat (8) @(posedge sys_clk);
      #1;
      `CHK(msr_rdata[31:0], c1 - 32'h2)
      wr(A0, {32'h32, 32'h0});
      #1;
      `CHK(msr_rdata[31:0], 32'h32)
      wr(A0 + 2, act(16'h0, 8'h10));
      wr(A0, {32'h2, 32'h0});
      repeat (6) @(posedge sys_clk);
      rd(A0, {32'h2, 32'h0});
      // second reset in mid-run clears every register
      @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd(A0, 64'h0);
      rd(A0 + 6, 64'h0);
      `CHK(async_error_out, 1'b0)
      report_and_stop();
   end
endmodule // test_descriptor_hit_stat_counter
